//--- core/bfp_supervisor.sv
// Fault protection, lockout, power-good and interrupt logic of a four-channel buck regulator.
`timescale 1ns/1ps
module bfp_supervisor
   import bfp_pkg::*;
#(
   parameter int SS_CYCLES = SOFT_START_CYCLES,
   parameter int PG_VALID = PG_VALID_CYCLES,
   parameter logic [7:0] PG_SELECT_RESET = PG_SELECT_RST
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire bfp_sense_s senseIn,
   input wire logic [3:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output bfp_drive_s driveOut,
   output logic [NCH-1:0] channelGood,
   output logic combinedGoodOut,
   output logic combinedGoodOe,
   output logic faultAlertOut,
   output logic faultAlertOe
);

   localparam int TW = $clog2(SS_CYCLES + 1);
   localparam int VW = $clog2(PG_VALID + 1);
   localparam int DW = $clog2(PG_DROP_CYCLES + 1);
   localparam logic [TW-1:0] SS_LAST = TW'(SS_CYCLES - 1);
   localparam logic [VW-1:0] VALID_LAST = VW'(PG_VALID);
   localparam logic [DW-1:0] DROP_LAST = DW'(PG_DROP_CYCLES);

   // Counts below two would make the soft-start timer compare against its reset value.
   if (SS_CYCLES < 2 || PG_VALID < 1) begin : gParamCheck
      $error("bfp_supervisor: SS_CYCLES must be at least 2 and PG_VALID at least 1");
   end

   // Folded rate gate: pass every cycle, every second or every fourth.
   function automatic logic foldAllow(input logic half, input logic quarter, input logic [1:0] cnt);
      foldAllow = quarter ? (cnt == 2'h0) : (half ? ~cnt[0] : 1'b1);
   endfunction : foldAllow

   // Duty skip gate: pass every cycle, every second or every third.
   function automatic logic skipAllow(input logic atMax, input logic beyond, input logic [1:0] cnt);
      skipAllow = (atMax || beyond) ? (cnt == 2'h0) : 1'b1;
   endfunction : skipAllow

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   ////////////////////////////////////////////////////////////////////////////////

   bfp_sense_s senseMeta;
   bfp_sense_s sense;
   bfp_sense_s senseLast;

   // Every pin is asynchronous to core_clk; only the second stage and its delayed copy are used.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         senseMeta <= '0;
         sense <= '0;
         senseLast <= '0;
      end else begin
         senseMeta <= senseIn;
         sense <= senseMeta;
         senseLast <= sense;
      end
   end

   logic [NCH-1:0] ocEvent;
   logic [NCH-1:0] swTick;
   assign ocEvent = sense.currentLimit & ~senseLast.currentLimit;
   assign swTick = sense.switchClk & ~senseLast.switchClk;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   ////////////////////////////////////////////////////////////////////////////////

   logic [7:0] latchCfg, next_latchCfg;
   logic [7:0] retryDis, next_retryDis;
   logic [7:0] pgSelect, next_pgSelect;
   logic [7:0] latchState, next_latchState;
   logic [5:0] faultFlags, next_faultFlags;
   logic [7:0] faultEnable, next_faultEnable;
   logic [7:0] next_regRdData;
   logic [NCH-1:0] shortSet, ovoltSet, goodFall;
   logic [NCH-1:0] next_channelGood;
   logic next_combinedGood;

   logic wrCfg, wrRetry, wrSel, wrLatch, wrFlags, wrEnable;
   assign wrCfg = regWrite && regAddr == REG_LATCH_CFG;
   assign wrRetry = regWrite && regAddr == REG_RETRY_DIS;
   assign wrSel = regWrite && regAddr == REG_PG_SELECT;
   assign wrLatch = regWrite && regAddr == REG_LATCH_STATE;
   assign wrFlags = regWrite && regAddr == REG_FAULT_FLAGS;
   assign wrEnable = regWrite && regAddr == REG_FAULT_ENABLE;

   // Register writes, sticky status and the registered read port; hardware sets beat clears.
   always_comb begin
      logic [7:0] latchClr;
      logic [5:0] flagSet;
      logic [5:0] flagClr;
      latchClr = '0;
      flagSet = '0;
      flagClr = '0;
      next_latchCfg = wrCfg ? regWrData : latchCfg;
      next_retryDis = wrRetry ? regWrData : retryDis;
      next_pgSelect = wrSel ? regWrData : pgSelect;
      next_faultEnable = wrEnable ? regWrData : faultEnable;
      if (wrLatch) begin
         latchClr[SHORT_LSB +: NCH] = regWrData[SHORT_LSB +: NCH] & ~sense.currentLimit;
         latchClr[OVOLT_LSB +: NCH] = regWrData[OVOLT_LSB +: NCH] & ~sense.overVolt;
      end
      next_latchState = latchState & ~latchClr;
      next_latchState[SHORT_LSB +: NCH] = next_latchState[SHORT_LSB +: NCH] | shortSet;
      next_latchState[OVOLT_LSB +: NCH] = next_latchState[OVOLT_LSB +: NCH] | ovoltSet;
      flagSet[FLAG_GOOD_LSB +: NCH] = goodFall;
      flagSet[FLAG_LOW_SUPPLY] = sense.firstSupplyWarn;
      flagSet[FLAG_OVER_TEMP] = sense.overTemp;
      if (wrFlags) begin
         flagClr = regWrData[5:0];
      end
      if (sense.enable == '0) begin
         flagClr = '1;
      end
      next_faultFlags = (faultFlags & ~flagClr) | flagSet;
      case (regAddr)
         REG_LATCH_CFG: next_regRdData = latchCfg;
         REG_RETRY_DIS: next_regRdData = retryDis;
         REG_PG_SELECT: next_regRdData = pgSelect;
         REG_LATCH_STATE: next_regRdData = latchState;
         REG_GOOD_READ: next_regRdData = {3'h0, combinedGoodOe == 1'b0, channelGood};
         REG_FAULT_FLAGS: next_regRdData = {2'h0, faultFlags};
         REG_FAULT_ENABLE: next_regRdData = faultEnable;
         default: next_regRdData = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         latchCfg <= LATCH_CFG_RST;
         retryDis <= RETRY_DIS_RST;
         pgSelect <= PG_SELECT_RESET;
         latchState <= 8'h00;
         faultFlags <= 6'h00;
         faultEnable <= FAULT_ENABLE_RST;
         regRdData <= 8'h00;
      end else begin
         latchCfg <= next_latchCfg;
         retryDis <= next_retryDis;
         pgSelect <= next_pgSelect;
         latchState <= next_latchState;
         faultFlags <= next_faultFlags;
         faultEnable <= next_faultEnable;
         regRdData <= next_regRdData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Channel sequencing: lockout, soft start, retry and latch-off
   ////////////////////////////////////////////////////////////////////////////////

   bfp_ch_state_e chState [NCH];
   bfp_ch_state_e next_chState [NCH];
   logic [TW-1:0] timer [NCH];
   logic [TW-1:0] next_timer [NCH];
   logic [2:0] periodCnt [NCH];
   logic [2:0] next_periodCnt [NCH];
   logic [3:0] ocCount [NCH];
   logic [3:0] next_ocCount [NCH];
   logic [2:0] restarts [NCH];
   logic [2:0] next_restarts [NCH];
   logic [NCH-1:0] firstSoft, next_firstSoft;
   logic [NCH-1:0] lockout, next_lockout;

   // One state machine per channel; disable, lockout and latch-off all override the retry path.
   always_comb begin
      logic retryOff;
      logic shortOn;
      logic ovoltOn;
      retryOff = 1'b0;
      shortOn = 1'b0;
      ovoltOn = 1'b0;
      shortSet = '0;
      ovoltSet = '0;
      for (int c = 0; c < NCH; c++) begin
         next_chState[c] = chState[c];
         next_timer[c] = timer[c];
         next_periodCnt[c] = periodCnt[c];
         next_ocCount[c] = ocCount[c];
         next_restarts[c] = restarts[c];
         next_firstSoft[c] = firstSoft[c];
         // Hysteretic lockout: falls below the low threshold, recovers above the high one.
         if (sense.supplyLow[c]) begin
            next_lockout[c] = 1'b1;
         end else if (sense.supplyHigh[c]) begin
            next_lockout[c] = 1'b0;
         end else begin
            next_lockout[c] = lockout[c];
         end
         retryOff = retryDis[c];
         shortOn = (latchCfg[SHORT_LSB + c] | sense.fuseShortLatch[c]) & ~retryOff;
         ovoltOn = latchCfg[OVOLT_LSB + c] | sense.fuseOvoltLatch[c];
         if (!sense.enable[c] || lockout[c] || lockout[0]) begin
            next_chState[c] = CH_OFF;
            next_timer[c] = '0;
            next_periodCnt[c] = '0;
            next_ocCount[c] = '0;
            next_restarts[c] = '0;
         end else begin
            case (chState[c])
               CH_OFF: begin
                  next_chState[c] = CH_SOFT;
                  next_firstSoft[c] = 1'b1;
               end
               CH_SOFT, CH_RUN: begin
                  next_timer[c] = (timer[c] == SS_LAST) ? timer[c] : timer[c] + TW'(1);
                  if (timer[c] == SS_LAST) begin
                     next_firstSoft[c] = 1'b0;
                     next_chState[c] = CH_RUN;
                     // A full fault-free soft-start period in run breaks the restart chain.
                     if (chState[c] == CH_RUN) begin
                        next_restarts[c] = '0;
                     end else begin
                        next_timer[c] = '0;
                     end
                  end
                  if (ocEvent[c] && !firstSoft[c] && !retryOff) begin
                     next_ocCount[c] = ocCount[c] + 4'h1;
                     if (ocCount[c] == OC_COUNT_MAX) begin
                        next_ocCount[c] = '0;
                        next_timer[c] = '0;
                        next_periodCnt[c] = '0;
                        if (shortOn && restarts[c] == RESTART_LIMIT) begin
                           next_chState[c] = CH_LATCHED;
                           shortSet[c] = 1'b1;
                        end else begin
                           next_chState[c] = CH_HICCUP;
                           next_restarts[c] = restarts[c] + 3'h1;
                        end
                     end
                  end
               end
               CH_HICCUP: begin
                  next_timer[c] = timer[c] + TW'(1);
                  if (timer[c] == SS_LAST) begin
                     next_timer[c] = '0;
                     next_periodCnt[c] = periodCnt[c] + 3'h1;
                     if (periodCnt[c] == HICCUP_PERIODS - 3'h1) begin
                        next_chState[c] = CH_SOFT;
                        next_periodCnt[c] = '0;
                     end
                  end
               end
               CH_LATCHED: next_chState[c] = CH_LATCHED;
               default: next_chState[c] = CH_OFF;
            endcase
            if (ovoltOn && sense.overVolt[c] && chState[c] != CH_OFF && chState[c] != CH_LATCHED) begin
               next_chState[c] = CH_LATCHED;
               ovoltSet[c] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < NCH; c++) begin
            chState[c] <= CH_OFF;
            timer[c] <= '0;
            periodCnt[c] <= '0;
            ocCount[c] <= '0;
            restarts[c] <= '0;
         end
         firstSoft <= '1;
         lockout <= '1;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            chState[c] <= next_chState[c];
            timer[c] <= next_timer[c];
            periodCnt[c] <= next_periodCnt[c];
            ocCount[c] <= next_ocCount[c];
            restarts[c] <= next_restarts[c];
         end
         firstSoft <= next_firstSoft;
         lockout <= next_lockout;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Switching-cycle gating: foldback, duty skip and cycle current limit
   ////////////////////////////////////////////////////////////////////////////////

   logic [1:0] foldCnt [NCH];
   logic [1:0] next_foldCnt [NCH];
   logic [1:0] skipCnt [NCH];
   logic [1:0] next_skipCnt [NCH];
   logic [NCH-1:0] limitHit, next_limitHit;
   bfp_drive_s next_drive;

   // Pulse enables change only on an oscillator edge unless the channel stops running; a current-limit event cuts the high side mid-cycle.
   always_comb begin
      logic running;
      logic [1:0] skipMod;
      running = 1'b0;
      skipMod = 2'h1;
      next_drive = driveOut;
      for (int c = 0; c < NCH; c++) begin
         running = (chState[c] == CH_SOFT) || (chState[c] == CH_RUN);
         skipMod = sense.dutyBeyond[c] ? 2'h3 : 2'h2;
         next_foldCnt[c] = foldCnt[c];
         next_skipCnt[c] = skipCnt[c];
         next_limitHit[c] = limitHit[c] | ocEvent[c];
         if (swTick[c]) begin
            next_foldCnt[c] = foldCnt[c] + 2'h1;
            next_skipCnt[c] = (skipCnt[c] >= skipMod - 2'h1) ? 2'h0 : skipCnt[c] + 2'h1;
            next_limitHit[c] = ocEvent[c];
            next_drive.pulseEnable[c] = running
               && foldAllow(sense.fbHalfLow[c], sense.fbQuarterLow[c], foldCnt[c])
               && skipAllow(sense.dutyMax[c], sense.dutyBeyond[c], skipCnt[c]);
         end
         if (!running) begin
            next_drive.pulseEnable[c] = 1'b0;
         end
         next_drive.highSideEnable[c] = next_drive.pulseEnable[c] && !next_limitHit[c];
         next_drive.lowSideForce[c] = running && next_limitHit[c];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < NCH; c++) begin
            foldCnt[c] <= '0;
            skipCnt[c] <= '0;
         end
         limitHit <= '0;
         driveOut <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            foldCnt[c] <= next_foldCnt[c];
            skipCnt[c] <= next_skipCnt[c];
         end
         limitHit <= next_limitHit;
         driveOut <= next_drive;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power-good qualification and open-drain outputs
   ////////////////////////////////////////////////////////////////////////////////

   logic [DW-1:0] dropCnt [NCH];
   logic [DW-1:0] next_dropCnt [NCH];
   logic [VW-1:0] validCnt, next_validCnt;
   logic combinedGood;

   // Drop filter rides out short sags; combined output needs a long clean window to rise.
   always_comb begin
      logic selectedGood;
      selectedGood = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         next_channelGood[c] = channelGood[c];
         next_dropCnt[c] = '0;
         if (sense.outGood[c]) begin
            next_channelGood[c] = 1'b1;
         end else if (sense.outLow[c] && channelGood[c]) begin
            next_dropCnt[c] = dropCnt[c] + DW'(1);
            if (dropCnt[c] == DROP_LAST) begin
               next_channelGood[c] = 1'b0;
               next_dropCnt[c] = '0;
            end
         end
      end
      goodFall = channelGood & ~next_channelGood;
      selectedGood = &(channelGood | ~pgSelect[NCH-1:0]);
      if (!selectedGood) begin
         next_validCnt = '0;
         next_combinedGood = 1'b0;
      end else if (validCnt == VALID_LAST) begin
         next_validCnt = validCnt;
         next_combinedGood = 1'b1;
      end else begin
         next_validCnt = validCnt + VW'(1);
         next_combinedGood = combinedGood;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < NCH; c++) begin
            dropCnt[c] <= '0;
         end
         channelGood <= '0;
         validCnt <= '0;
         combinedGood <= 1'b0;
         combinedGoodOut <= 1'b0;
         combinedGoodOe <= 1'b1;
         faultAlertOut <= 1'b0;
         faultAlertOe <= 1'b0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            dropCnt[c] <= next_dropCnt[c];
         end
         channelGood <= next_channelGood;
         validCnt <= next_validCnt;
         combinedGood <= next_combinedGood;
         combinedGoodOut <= 1'b0;
         combinedGoodOe <= !next_combinedGood;
         faultAlertOut <= 1'b0;
         faultAlertOe <= |(next_faultFlags & faultEnable[5:0]);
      end
   end

endmodule : bfp_supervisor

//--- core/bfp_pkg.sv
// Package with register map, field layout, timing constants and types of the buck fault supervisor.
package bfp_pkg;

   localparam int NCH = 4;

   // Register indices on the register access port.
   localparam logic [3:0] REG_LATCH_CFG = 4'h7;
   localparam logic [3:0] REG_RETRY_DIS = 4'ha;
   localparam logic [3:0] REG_PG_SELECT = 4'hb;
   localparam logic [3:0] REG_LATCH_STATE = 4'hc;
   localparam logic [3:0] REG_GOOD_READ = 4'hd;
   localparam logic [3:0] REG_FAULT_FLAGS = 4'he;
   localparam logic [3:0] REG_FAULT_ENABLE = 4'hf;

   // Field positions.
   localparam int SHORT_LSB = 0;
   localparam int OVOLT_LSB = 4;
   localparam int FLAG_GOOD_LSB = 0;
   localparam int FLAG_LOW_SUPPLY = 4;
   localparam int FLAG_OVER_TEMP = 5;
   localparam int GOOD_RD_COMBINED = 4;

   // Reset values.
   localparam logic [7:0] LATCH_CFG_RST = 8'h00;
   localparam logic [7:0] RETRY_DIS_RST = 8'h00;
   localparam logic [7:0] PG_SELECT_RST = 8'h01;
   localparam logic [7:0] FAULT_ENABLE_RST = 8'h00;

   // Timing, in printed units, and derived cycle counts at the core clock rate.
   localparam int CLK_MHZ = 50;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SOFT_START_TIME_US = 2000;
   localparam int SOFT_START_CYCLES = SOFT_START_TIME_US * CLK_MHZ;
   localparam int PG_DROP_TIME_NS = 50000;
   localparam int PG_DROP_CYCLES = (PG_DROP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PG_VALID_TIME_US = 1000;
   localparam int PG_VALID_CYCLES = PG_VALID_TIME_US * CLK_MHZ;

   // Fault counting limits.
   localparam logic [3:0] OC_COUNT_MAX = 4'hf;
   localparam logic [2:0] HICCUP_PERIODS = 3'h7;
   localparam logic [2:0] RESTART_LIMIT = 3'h7;

   // Channel sequencing states, one-hot.
   typedef enum logic [4:0] {
      CH_OFF = 5'h01,
      CH_SOFT = 5'h02,
      CH_RUN = 5'h04,
      CH_HICCUP = 5'h08,
      CH_LATCHED = 5'h10
   } bfp_ch_state_e;

   // Comparator, enable, oscillator and fuse levels from the power stage, one bit per channel except the shared overTemp and firstSupplyWarn.
   typedef struct packed {
      logic [NCH-1:0] fbHalfLow;
      logic [NCH-1:0] fbQuarterLow;
      logic [NCH-1:0] dutyMax;
      logic [NCH-1:0] dutyBeyond;
      logic [NCH-1:0] currentLimit;
      logic [NCH-1:0] overVolt;
      logic [NCH-1:0] outGood;
      logic [NCH-1:0] outLow;
      logic [NCH-1:0] supplyHigh;
      logic [NCH-1:0] supplyLow;
      logic [NCH-1:0] enable;
      logic [NCH-1:0] switchClk;
      logic [NCH-1:0] fuseShortLatch;
      logic [NCH-1:0] fuseOvoltLatch;
      logic overTemp;
      logic firstSupplyWarn;
   } bfp_sense_s;

   // Per-channel gate drive permissions.
   typedef struct packed {
      logic [NCH-1:0] pulseEnable;
      logic [NCH-1:0] highSideEnable;
      logic [NCH-1:0] lowSideForce;
   } bfp_drive_s;

endpackage : bfp_pkg

//--- bench/bfp_stage_model.sv
// Power-stage stand-in that passes comparator levels through and runs the oscillators.
`timescale 1ns/1ps
module bfp_stage_model
   import bfp_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire bfp_sense_s levels,
   output bfp_sense_s senseOut
);
   logic [3:0] phase;
   ////////////////////////////////////////
   // Free-running phase; a real oscillator never stops, so neither does this one.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         phase <= 4'h0;
      end else begin
         phase <= phase + 4'h1;
      end
   end
   // Every channel starts a switching cycle once per sixteen core cycles.
   always_comb begin
      senseOut = levels;
      senseOut.switchClk = {NCH{phase[3]}};
   end
endmodule : bfp_stage_model

//--- bench/bfp_supervisor_checker.sv
// Port-level checks of the buck fault supervisor.
`timescale 1ns/1ps
module bfp_supervisor_checker
   import bfp_pkg::*;
#(
   parameter int PG_VALID = PG_VALID_CYCLES
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire bfp_sense_s senseIn,
   input wire logic [3:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire bfp_drive_s driveOut,
   input wire logic [NCH-1:0] channelGood,
   input wire logic combinedGoodOut,
   input wire logic combinedGoodOe,
   input wire logic faultAlertOut,
   input wire logic faultAlertOe
);
   logic [7:0] enShadow;
   logic [7:0] selShadow;
   logic [15:0] goodCnt;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////
   // Mirrors of the written enables, and a run length of all selected flags good.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         enShadow <= FAULT_ENABLE_RST;
         selShadow <= PG_SELECT_RST;
         goodCnt <= 16'h0000;
      end else begin
         if (regWrite && regAddr == REG_FAULT_ENABLE) enShadow <= regWrData;
         if (regWrite && regAddr == REG_PG_SELECT) selShadow <= regWrData;
         goodCnt <= ((channelGood & selShadow[3:0]) == selShadow[3:0]) ? goodCnt + 16'h0001 : 16'h0000;
      end
   end
   ////////////////////////////////////////
   a_open_drain_low: assert property (combinedGoodOut == 1'b0 && faultAlertOut == 1'b0)
      else $error("open-drain data not low");
   a_alert_needs_enable: assert property (enShadow[5:0] == 6'h00 |=> !faultAlertOe)
      else $error("alert with no source enabled");
   a_alert_release_cause: assert property ($fell(faultAlertOe) |->
      ($past(regWrite) || $past(regWrite, 2) || $past(senseIn.enable, 3) == 4'h0 ||
      $past(senseIn.enable, 4) == 4'h0))
      else $error("alert released without clear");
   a_combined_drop_now: assert property (|(~channelGood & selShadow[3:0]) |=> combinedGoodOe)
      else $error("combined good not dropped");
   a_combined_valid_time: assert property ($fell(combinedGoodOe) |-> goodCnt >= PG_VALID)
      else $error("combined good rose early");
   a_drive_exclusive: assert property ((driveOut.highSideEnable & driveOut.lowSideForce) == 4'h0)
      else $error("high side on while low side forced");
   a_good_readback: assert property (($past(regAddr) == REG_GOOD_READ && $stable(channelGood))
      |-> regRdData[3:0] == channelGood)
      else $error("good readback mismatch");
   a_unmapped_zero: assert property (($past(regAddr) < 4'h7 || $past(regAddr) inside {4'h8, 4'h9})
      |-> regRdData == 8'h00)
      else $error("unmapped read not zero");
endmodule : bfp_supervisor_checker

bind bfp_supervisor bfp_supervisor_checker #(.PG_VALID(PG_VALID)) chk (.core_clk(core_clk), .resetn(resetn),
   .senseIn(senseIn), .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
   .driveOut(driveOut), .channelGood(channelGood), .combinedGoodOut(combinedGoodOut),
   .combinedGoodOe(combinedGoodOe), .faultAlertOut(faultAlertOut), .faultAlertOe(faultAlertOe));

//--- bench/tb_top.sv
// Register-level testbench of the buck fault supervisor.
`timescale 1ns/1ps
module tb_top;
   import bfp_pkg::*;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   bfp_sense_s lv;
   bfp_sense_s sense;
   logic [3:0] regAddr = 4'h0;
   logic regWrite = 1'b0;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData;
   bfp_drive_s driveOut;
   logic [NCH-1:0] channelGood;
   logic combinedGoodOe;
   logic faultAlertOe;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [3:0] addrs [8] = '{4'h7, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h0};
   logic [7:0] rsts [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   always #10 core_clk = ~core_clk;
   bfp_stage_model stage (.core_clk(core_clk), .resetn(resetn), .levels(lv), .senseOut(sense));
   bfp_supervisor #(.SS_CYCLES(20), .PG_VALID(10)) uut (.core_clk(core_clk), .resetn(resetn), .senseIn(sense),
      .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
      .driveOut(driveOut), .channelGood(channelGood), .combinedGoodOut(), .combinedGoodOe(combinedGoodOe),
      .faultAlertOut(), .faultAlertOe(faultAlertOe));
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic pause(input int n);
      repeat (n) @(negedge core_clk);
   endtask : pause
   // Writes are one-cycle strobes launched on the falling edge.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge core_clk);
      regWrite = 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      regAddr = a;
      @(negedge core_clk);
      chk(regRdData, exp);
   endtask : rd
   // Counts cycles with channel 0 pulses allowed over a window that spans whole fold and skip periods.
   task automatic pulses(input logic [7:0] exp);
      logic [7:0] n;
      n = 8'h00;
      pause(64);
      repeat (192) begin
         n = n + {7'h0, driveOut.pulseEnable[0]};
         @(negedge core_clk);
      end
      chk(n, exp);
   endtask : pulses
   task automatic results;
      if (errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   // Cuts a hang short; the whole sequence needs a little over four thousand cycles.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("[FAIL] %0t timeout", $time);
         results();
      end
   end
   ////////////////////////////////////////
   // Main sequence: reset values, interrupt flags, power-good qualification.
   initial begin
      lv = '0;
      lv.supplyHigh = 4'hf;
      lv.enable = 4'hf;
      pause(12);
      resetn = 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(addrs[i], rsts[i]);
      end
      wr(4'hf, 8'h3f);
      rd(4'hf, 8'h3f);
      wr(4'hd, 8'hff);
      rd(4'hd, 8'h00);
      wr(4'hf, 8'h00);
      lv.overTemp = 1'b1;
      pause(6);
      rd(4'he, 8'h20);
      chk({7'h0, faultAlertOe}, 8'h00);
      wr(4'hf, 8'h20);
      pause(3);
      chk({7'h0, faultAlertOe}, 8'h01);
      lv.overTemp = 1'b0;
      pause(4);
      wr(4'he, 8'h00);
      pause(3);
      rd(4'he, 8'h20);
      chk({7'h0, faultAlertOe}, 8'h01);
      wr(4'he, 8'h20);
      pause(3);
      rd(4'he, 8'h00);
      chk({7'h0, faultAlertOe}, 8'h00);
      lv.firstSupplyWarn = 1'b1;
      pause(6);
      lv.firstSupplyWarn = 1'b0;
      rd(4'he, 8'h10);
      lv.enable = 4'h0;
      pause(6);
      rd(4'he, 8'h00);
      lv.enable = 4'hf;
      lv.outGood = 4'h1;
      pause(5);
      chk({7'h0, combinedGoodOe}, 8'h01);
      pause(20);
      chk({7'h0, combinedGoodOe}, 8'h00);
      rd(4'hd, 8'h11);
      wr(4'hb, 8'h03);
      pause(1);
      chk({7'h0, combinedGoodOe}, 8'h01);
      wr(4'hb, 8'h01);
      lv.outGood = 4'h0;
      lv.outLow = 4'h1;
      pause(2400);
      chk({4'h0, channelGood}, 8'h01);
      pause(200);
      chk({4'h0, channelGood}, 8'h00);
      chk({7'h0, combinedGoodOe}, 8'h01);
      rd(4'he, 8'h01);
      pulses(8'hc0);
      lv.fbHalfLow = 4'h1;
      pulses(8'h60);
      lv.fbQuarterLow = 4'h1;
      pulses(8'h30);
      lv.fbHalfLow = 4'h0;
      lv.fbQuarterLow = 4'h0;
      lv.dutyMax = 4'h1;
      pulses(8'h60);
      lv.dutyBeyond = 4'h1;
      pulses(8'h40);
      lv.dutyMax = 4'h0;
      lv.dutyBeyond = 4'h0;
      lv.currentLimit = 4'h1;
      pause(3);
      chk({6'h0, driveOut.highSideEnable[0], driveOut.lowSideForce[0]}, 8'h01);
      lv.currentLimit = 4'h0;
      wr(4'h7, 8'h10);
      lv.overVolt = 4'h1;
      pause(4);
      rd(4'hc, 8'h10);
      wr(4'hc, 8'h10);
      rd(4'hc, 8'h10);
      lv.overVolt = 4'h0;
      pause(3);
      wr(4'hc, 8'h10);
      rd(4'hc, 8'h00);
      chk({7'h0, driveOut.pulseEnable[0]}, 8'h00);
      lv.enable = 4'he;
      pause(6);
      lv.enable = 4'hf;
      pulses(8'hc0);
      results();
   end
endmodule : tb_top
